//--- rtl/lockout_params.svh
// Contract
// RL1 - Copy display ident data to computers once at power-up, never again.
// RL2 - Block every computer-started write on the display ident channel.
// RL3 - Enclosure opening seen by the tamper monitor disables the device permanently.
// RL4 - Backup source failure or depletion counts as a tamper event.
// RL5 - Tamper detection runs from backup power, so unpowered events are caught.
// RL6 - After tamper, no shared peripheral is connected to any computer.
// RL7 - A clear user indication shows whenever tampering was detected.
// RL8 - While tamper protection is active, programming ports are denied.
// RL9 - Self-test runs at every power-up before switching is enabled. Not started when tamper is seen at power-up.
// RL10 - Failed self-test disables the device and isolates all inputs from outputs.
// RL11 - Tamper function failure isolates peripherals from computers.
// RL12 - A distinct user indication shows a failed power-up self-test.
// RL13 - Tamper state lives in a backup latch no reset or power cycle clears.
`ifndef LOCKOUT_PARAMS_SVH
`define LOCKOUT_PARAMS_SVH

// Clock rate and timeouts
`define CLK_MHZ        20
`define ST_TIMEOUT_US  10000
`define TMO_W          18

// Cycles the synchronisers need before their outputs are trusted
`define SETTLE_CYC     4'h8
`define SETTLE_W       4

// Synchronised input positions
`define NSYNC          6
`define IX_OPEN        0
`define IX_BATT        1
`define IX_MON         2
`define IX_LATCH       3
`define IX_HWR         4
`define IX_ARM         5

`endif

//--- rtl/lockout_pkg.sv
package lockout_pkg;

  // Lockout sequencer states
  typedef enum logic [2:0] {
    ST_SETTLE = 3'b000,
    ST_TEST   = 3'b001,
    ST_COPY   = 3'b010,
    ST_RUN    = 3'b011,
    ST_FAIL   = 3'b100,
    ST_TAMP   = 3'b101
  } seq_state_t;

endpackage

//--- rtl/tamper_selftest_lockout.sv
`timescale 1ns/1ns
`default_nettype none
`include "lockout_params.svh"
module tamper_selftest_lockout #(
  parameter int unsigned TMO_CYC = `ST_TIMEOUT_US * `CLK_MHZ
) (
  input  wire logic SYS_CLK,        // 20 MHz system clock
  input  wire logic RST,            // Async reset, active high
  input  wire logic TAMPER_OPEN,    // Enclosure switch, high when open
  input  wire logic BATT_FAIL,      // Backup source failed or depleted
  input  wire logic MON_OK,         // Tamper monitor reports healthy
  input  wire logic TAMPER_LATCH,   // Backup-domain latch, high once tampered
  input  wire logic HOST_WR,        // Computer drives a write on ident channel
  input  wire logic ARMED,          // Strap: tamper protection armed
  input  wire logic ST_DONE,        // Self-test engine finished
  input  wire logic ST_PASS,        // Self-test result, valid with ST_DONE
  input  wire logic COPY_DONE,      // Ident copy engine finished
  output logic      TAMPER_SET,     // Sets the backup-domain latch
  output logic      ST_START,       // One-cycle self-test start
  output logic      IDENT_COPY,     // Ident copy display to computers enabled
  output logic      WR_BLOCK,       // Computer writes on ident channel cut
  output logic      WR_BLOCKED,     // Pulse per blocked write attempt
  output logic      PERIPH_CONNECT, // Shared peripherals joined to computer
  output logic      VIDEO_ENABLE,   // Video and other input-output paths on
  output logic      PROG_PORT_EN,   // Internal programming ports reachable
  output logic      LED_TAMPER,     // Tamper indication
  output logic      LED_FAULT,      // Self-test failure indication
  output logic      LED_READY       // Normal switching indication
);

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  // Sync stages per pin; stab holds the agreed value
  logic [`NSYNC-1:0] pins;
  logic [`NSYNC-1:0] s1;
  logic [`NSYNC-1:0] s2;
  logic [`NSYNC-1:0] s3;
  logic [`NSYNC-1:0] stab;

  // Pin order fixed by the index defines
  assign pins[`IX_OPEN]  = TAMPER_OPEN;
  assign pins[`IX_BATT]  = BATT_FAIL;
  assign pins[`IX_MON]   = MON_OK;
  assign pins[`IX_LATCH] = TAMPER_LATCH;
  assign pins[`IX_HWR]   = HOST_WR;
  assign pins[`IX_ARM]   = ARMED;

  // Three stages; a change counts only once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < `NSYNC; g = g + 1) begin : g_sync
      always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
          s1[g]   <= 1'b0;
          s2[g]   <= 1'b0;
          s3[g]   <= 1'b0;
          stab[g] <= 1'b0;
        end else begin
          s1[g] <= pins[g];
          s2[g] <= s1[g];
          s3[g] <= s2[g];
          if (s2[g] == s3[g]) begin
            stab[g] <= s3[g];
          end
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Settle counter; nothing is judged until the synchronisers hold real data

  logic [`SETTLE_W-1:0] settle;
  logic                 settled;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      settle  <= '0;
      settled <= 1'b0;
    end else if (!settled) begin
      settle <= settle + 1'b1;
      if (settle == `SETTLE_CYC) begin
        settled <= 1'b1;
      end
    end
  end

  // Strap caught once the synchronised value is trustworthy
  logic armed;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      armed <= 1'b1;
    end else if (!settled && settle == `SETTLE_CYC) begin
      armed <= stab[`IX_ARM];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Tamper capture

  // Latch read covers events caught by the backup domain while unpowered
  logic tamper_evt;
  assign tamper_evt = settled && (stab[`IX_OPEN]     // RL3
                               || stab[`IX_BATT]     // RL4
                               || stab[`IX_LATCH]);  // RL5

  // Sticky; only reset clears it, and reset re-reads the backup latch
  logic tampered;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      tampered <= 1'b0;
    end else if (tamper_evt) begin
      tampered <= 1'b1; // RL3
    end
  end

  // Monitor health loss is sticky as well
  logic mon_fail;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      mon_fail <= 1'b0;
    end else if (settled && !stab[`IX_MON]) begin
      mon_fail <= 1'b1; // RL11
    end
  end

  // Drive the backup latch; it then holds across resets and power cycles
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      TAMPER_SET <= 1'b0;
    end else if (tamper_evt || tampered) begin
      TAMPER_SET <= 1'b1; // RL13
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Power-up sequencer

  // Sequencer state and its watchdog
  lockout_pkg::seq_state_t state;
  logic [`TMO_W-1:0]       timer;
  logic                    copied;
  logic                    tmo;

  // Timeout shared by test and copy; a hung engine cannot stall boot
  assign tmo = (timer == `TMO_W'(TMO_CYC));

  // Tamper beats every other transition; tamper is terminal, and fail leaves only for tamper
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state <= lockout_pkg::ST_SETTLE;
    end else if (tamper_evt || tampered) begin
      state <= lockout_pkg::ST_TAMP; // RL3
    end else begin
      case (state)
        lockout_pkg::ST_SETTLE: begin
          if (settled) begin
            state <= lockout_pkg::ST_TEST; // RL9
          end
        end
        lockout_pkg::ST_TEST: begin
          if (mon_fail) begin
            state <= lockout_pkg::ST_FAIL; // RL11
          end else if ((ST_DONE && !ST_PASS) || tmo) begin
            state <= lockout_pkg::ST_FAIL; // RL10
          end else if (ST_DONE && !copied) begin
            state <= lockout_pkg::ST_COPY; // RL1
          end else if (ST_DONE) begin
            state <= lockout_pkg::ST_RUN;
          end
        end
        lockout_pkg::ST_COPY: begin
          if (mon_fail || tmo) begin
            state <= lockout_pkg::ST_FAIL;
          end else if (COPY_DONE) begin
            state <= lockout_pkg::ST_RUN;
          end
        end
        lockout_pkg::ST_RUN: begin
          if (mon_fail) begin
            state <= lockout_pkg::ST_FAIL; // RL11
          end
        end
        lockout_pkg::ST_FAIL: state <= lockout_pkg::ST_FAIL;
        lockout_pkg::ST_TAMP: state <= lockout_pkg::ST_TAMP;
        default: state <= lockout_pkg::ST_FAIL;
      endcase
    end
  end

  // Timeout counter; restarts on every state change
  lockout_pkg::seq_state_t prev_state;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      prev_state <= lockout_pkg::ST_SETTLE;
      timer      <= '0;
    end else begin
      prev_state <= state;
      if (state != prev_state) begin
        timer <= '0;
      end else if (!tmo) begin
        timer <= timer + 1'b1;
      end
    end
  end

  // Copy may be entered once per power-up and never afterwards
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      copied <= 1'b0;
    end else if (state == lockout_pkg::ST_COPY) begin
      copied <= 1'b1; // RL1
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Handshake outputs

  // Start pulse on the first cycle of the test state
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ST_START <= 1'b0;
    end else begin
      ST_START <= (state == lockout_pkg::ST_SETTLE) && settled
                  && !tamper_evt && !tampered; // RL9
    end
  end

  // Copy window; cut the same cycle a tamper or timeout appears
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      IDENT_COPY <= 1'b0;
    end else begin
      IDENT_COPY <= (state == lockout_pkg::ST_COPY) && !COPY_DONE
                    && !tamper_evt && !mon_fail && !tmo; // RL1
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Ident channel write guard

  // Writes are never passed; the path is cut in hardware, not filtered
  logic hwr_prev;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      WR_BLOCK   <= 1'b1;
      WR_BLOCKED <= 1'b0;
      hwr_prev   <= 1'b0;
    end else begin
      WR_BLOCK   <= 1'b1; // RL2
      hwr_prev   <= stab[`IX_HWR];
      WR_BLOCKED <= stab[`IX_HWR] && !hwr_prev; // RL2
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Path enables and indications

  // Paths open only in run; one cycle of lag is the price of flopped outputs
  logic run_ok;
  assign run_ok = (state == lockout_pkg::ST_RUN) && !tamper_evt && !mon_fail;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      PERIPH_CONNECT <= 1'b0;
      VIDEO_ENABLE   <= 1'b0;
    end else begin
      PERIPH_CONNECT <= run_ok && !tampered; // RL6 RL10 RL11
      VIDEO_ENABLE   <= run_ok && !tampered; // RL10
    end
  end

  // Programming ports stay shut while armed or once tampered
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      PROG_PORT_EN <= 1'b0;
    end else begin
      PROG_PORT_EN <= settled && !armed && !tampered && !tamper_evt; // RL8
    end
  end

  // Tamper and self-test failure light different lamps
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      LED_TAMPER <= 1'b0;
      LED_FAULT  <= 1'b0;
      LED_READY  <= 1'b0;
    end else begin
      LED_TAMPER <= tampered || tamper_evt; // RL7
      LED_FAULT  <= (state == lockout_pkg::ST_FAIL) && !tampered; // RL12
      LED_READY  <= run_ok && !tampered;
    end
  end

endmodule
`default_nettype wire

//--- verif/lockout_partner.sv
`timescale 1ns/1ns
`default_nettype none
module lockout_partner (
  input  wire logic clk,         // System clock
  input  wire logic st_start,    // Test start
  input  wire logic ident_copy,  // Copy window
  input  wire logic tamper_set,  // Latch set
  input  wire logic sensor_hit,  // Sensor trip
  input  wire logic pass_cfg,    // Verdict to give
  input  wire logic hang,        // Test never ends
  input  wire logic new_unit,    // Fresh unit
  output logic      st_done,     // Test done
  output logic      st_pass,     // Test verdict
  output logic      copy_done,   // Copy done
  output logic      tamper_latch // Backup latch
);
  int st_cnt = 0;
  int cp_cnt = 0;
  initial begin
    st_done = 1'b0;
    st_pass = 1'b0;
    copy_done = 1'b0;
    tamper_latch = 1'b0;
  end
  // Backup domain has no clock and no reset; only a fresh unit is clear
  always @(posedge tamper_set or posedge sensor_hit or posedge new_unit)
    tamper_latch <= !new_unit;
  // Fixed answer spans; verdict toggles outside done so it cannot be trusted
  always @(negedge clk) begin
    st_cnt = st_start ? 1 : ((st_cnt == 0 || st_cnt == 4) ? 0 : st_cnt + 1);
    cp_cnt = (cp_cnt == 0) ? (ident_copy ? 1 : 0) : ((cp_cnt == 5) ? 0 : cp_cnt + 1);
    st_done <= st_cnt == 4 && !hang;
    st_pass <= (st_cnt == 4) ? pass_cfg : !st_pass;
    copy_done <= cp_cnt == 5;
  end
endmodule
`default_nettype wire

//--- verif/lockout_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module lockout_asserts (
  input wire logic SYS_CLK,        // Clock
  input wire logic RST,            // Reset
  input wire logic TAMPER_OPEN,    // Enclosure pin
  input wire logic BATT_FAIL,      // Backup pin
  input wire logic MON_OK,         // Monitor health
  input wire logic ST_DONE,        // Test done
  input wire logic ST_PASS,        // Verdict
  input wire logic IDENT_COPY,     // Copy window
  input wire logic WR_BLOCK,       // Write cut
  input wire logic WR_BLOCKED,     // Blocked pulse
  input wire logic PERIPH_CONNECT, // Peripherals on
  input wire logic VIDEO_ENABLE,   // Video on
  input wire logic PROG_PORT_EN,   // Prog ports on
  input wire logic LED_TAMPER,     // Tamper lamp
  input wire logic LED_FAULT,      // Fault lamp
  input wire logic LED_READY       // Ready lamp
);
  logic       cp_prev;
  logic       passed;
  logic [1:0] copies;
  // Copy windows since reset; saturates so a repeat cannot wrap away
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      cp_prev <= 1'b0;
      copies <= 2'h0;
    end else begin
      cp_prev <= IDENT_COPY;
      if (IDENT_COPY && !cp_prev && copies != 2'h3)
        copies <= copies + 2'h1;
    end
  end
  // A passed test since reset
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST)
      passed <= 1'b0;
    else if (ST_DONE && ST_PASS)
      passed <= 1'b1;
  end
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  sequence open_held;
    LED_READY && $rose(TAMPER_OPEN) ##0 TAMPER_OPEN [*5];
  endsequence
  sequence batt_held;
    LED_READY && $rose(BATT_FAIL) ##0 BATT_FAIL [*5];
  endsequence
  // Health loss takes one more flop than a tamper pin, so one more cycle
  sequence mon_lost;
    LED_READY && $fell(MON_OK) ##0 !MON_OK [*6];
  endsequence
  a_wr_always_cut: assert property (WR_BLOCK)
    else $error("write cut dropped");
  a_blocked_pulse: assert property (WR_BLOCKED |=> !WR_BLOCKED)
    else $error("blocked pulse too long");
  a_copy_once: assert property (copies < 2'h2)
    else $error("ident copied twice");
  a_switch_after_test: assert property (PERIPH_CONNECT |-> passed)
    else $error("switching before test");
  a_tamper_isolates: assert property (LED_TAMPER |-> !(PERIPH_CONNECT || VIDEO_ENABLE
    || PROG_PORT_EN || LED_READY)) else $error("tamper not isolated");
  a_tamper_sticky: assert property (LED_TAMPER |=> LED_TAMPER)
    else $error("tamper cleared");
  a_open_trips: assert property (open_held |=> LED_TAMPER)
    else $error("open not latched");
  a_batt_trips: assert property (batt_held |=> LED_TAMPER)
    else $error("backup loss not latched");
  a_fault_isolates: assert property (LED_FAULT |-> !(PERIPH_CONNECT || VIDEO_ENABLE
    || IDENT_COPY || LED_READY)) else $error("fault not isolated");
  a_mon_isolates: assert property (mon_lost |=> !PERIPH_CONNECT)
    else $error("monitor loss kept link");
endmodule
////////////////////////////////////////////////////////////////
bind tamper_selftest_lockout lockout_asserts u_chk (
  .SYS_CLK(SYS_CLK), .RST(RST), .TAMPER_OPEN(TAMPER_OPEN), .BATT_FAIL(BATT_FAIL),
  .MON_OK(MON_OK), .ST_DONE(ST_DONE), .ST_PASS(ST_PASS), .IDENT_COPY(IDENT_COPY),
  .WR_BLOCK(WR_BLOCK), .WR_BLOCKED(WR_BLOCKED), .PERIPH_CONNECT(PERIPH_CONNECT),
  .VIDEO_ENABLE(VIDEO_ENABLE), .PROG_PORT_EN(PROG_PORT_EN), .LED_TAMPER(LED_TAMPER),
  .LED_FAULT(LED_FAULT), .LED_READY(LED_READY));
`default_nettype wire

//--- verif/tb_tamper_selftest_lockout.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    checked++; \
    if ((e) !== (g)) begin \
      err_total++; \
      $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
    end \
  end
module tb_tamper_selftest_lockout;
  logic SYS_CLK = 1'b0, RST = 1'b1, TAMPER_OPEN = 1'b0, BATT_FAIL = 1'b0;
  logic MON_OK = 1'b1, HOST_WR = 1'b0, ARMED = 1'b0;
  logic pass_cfg = 1'b1, hang = 1'b0, new_unit = 1'b0;
  logic [7:0] copy_cyc = 8'h00;
  wire logic TAMPER_LATCH, ST_DONE, ST_PASS, COPY_DONE, TAMPER_SET, ST_START;
  wire logic IDENT_COPY, WR_BLOCK, WR_BLOCKED, PERIPH_CONNECT, VIDEO_ENABLE;
  wire logic PROG_PORT_EN, LED_TAMPER, LED_FAULT, LED_READY;
  int err_total = 0, checked = 0, waited;
  always #25 SYS_CLK = ~SYS_CLK;
  // Copy window length, cleared by reset like the design's own state
  always @(negedge SYS_CLK) copy_cyc <= RST ? 8'h00 : copy_cyc + {7'h00, IDENT_COPY};
  tamper_selftest_lockout #(.TMO_CYC(50)) dut (.SYS_CLK(SYS_CLK), .RST(RST),
    .TAMPER_OPEN(TAMPER_OPEN), .BATT_FAIL(BATT_FAIL), .MON_OK(MON_OK),
    .TAMPER_LATCH(TAMPER_LATCH), .HOST_WR(HOST_WR), .ARMED(ARMED), .ST_DONE(ST_DONE),
    .ST_PASS(ST_PASS), .COPY_DONE(COPY_DONE), .TAMPER_SET(TAMPER_SET),
    .ST_START(ST_START), .IDENT_COPY(IDENT_COPY), .WR_BLOCK(WR_BLOCK),
    .WR_BLOCKED(WR_BLOCKED), .PERIPH_CONNECT(PERIPH_CONNECT),
    .VIDEO_ENABLE(VIDEO_ENABLE), .PROG_PORT_EN(PROG_PORT_EN),
    .LED_TAMPER(LED_TAMPER), .LED_FAULT(LED_FAULT), .LED_READY(LED_READY));
  // Sensors reach the backup latch by themselves only while main power is off,
  // so powered trips must come through the design's own pin path
  lockout_partner u_far (.clk(SYS_CLK), .st_start(ST_START), .ident_copy(IDENT_COPY),
    .tamper_set(TAMPER_SET), .sensor_hit((TAMPER_OPEN | BATT_FAIL) & RST), .pass_cfg(pass_cfg),
    .hang(hang), .new_unit(new_unit), .st_done(ST_DONE), .st_pass(ST_PASS),
    .copy_done(COPY_DONE), .tamper_latch(TAMPER_LATCH));
  ////////////////////////////////////////////////////////////////
  task cyc(input int n);
    repeat (n) @(negedge SYS_CLK);
  endtask
  // Power cycle; waits for a verdict lamp, counting cycles after start
  task boot(input logic p, input logic h, input logic a, input logic fresh);
    @(negedge SYS_CLK);
    RST = 1'b1;
    pass_cfg = p;
    hang = h;
    ARMED = a;
    new_unit = fresh;
    cyc(12);
    new_unit = 1'b0;
    RST = 1'b0;
    cyc(9);
    `CHK("start_early", 1'b0, ST_START)
    cyc(1);
    if (!TAMPER_LATCH)
      `CHK("start", 1'b1, ST_START)
    waited = 0;
    while (!(LED_READY | LED_FAULT | LED_TAMPER) && waited < 300) begin
      cyc(1);
      waited++;
    end
  endtask
  task t_pass_boot;
    boot(1'b1, 1'b0, 1'b0, 1'b1);
    `CHK("ready", 1'b1, LED_READY)
    `CHK("periph", 1'b1, PERIPH_CONNECT)
    `CHK("video", 1'b1, VIDEO_ENABLE)
    `CHK("prog", 1'b1, PROG_PORT_EN)
    `CHK("copy_len", 8'h05, copy_cyc)
    cyc(100);
    `CHK("copy_again", 8'h05, copy_cyc)
  endtask
  task t_host_wr;
    logic [3:0] n;
    n = 4'h0;
    repeat (2) begin
      HOST_WR = 1'b1;
      cyc(3);
      HOST_WR = 1'b0;
      repeat (6) begin
        cyc(1);
        n = n + {3'h0, WR_BLOCKED};
      end
    end
    `CHK("blocked", 4'h2, n)
    `CHK("wr_block", 1'b1, WR_BLOCK)
  endtask
  task t_fail_boot;
    boot(1'b0, 1'b0, 1'b0, 1'b0);
    `CHK("fault", 1'b1, LED_FAULT)
    `CHK("tamper", 1'b0, LED_TAMPER)
    `CHK("periph", 1'b0, PERIPH_CONNECT | VIDEO_ENABLE)
    `CHK("copy_len", 8'h00, copy_cyc)
  endtask
  task t_timeout;
    boot(1'b1, 1'b1, 1'b0, 1'b0);
    `CHK("fault", 1'b1, LED_FAULT)
    `CHK("tmo_span", 1'b1, waited >= 50 && waited <= 55)
  endtask
  task t_armed;
    boot(1'b1, 1'b0, 1'b1, 1'b0);
    `CHK("ready", 1'b1, LED_READY)
    `CHK("prog", 1'b0, PROG_PORT_EN)
  endtask
  task t_mon_fail;
    boot(1'b1, 1'b0, 1'b0, 1'b0);
    MON_OK = 1'b0;
    cyc(8);
    `CHK("fault", 1'b1, LED_FAULT)
    `CHK("periph", 1'b0, PERIPH_CONNECT | VIDEO_ENABLE)
    MON_OK = 1'b1;
  endtask
  task t_batt;
    boot(1'b1, 1'b0, 1'b0, 1'b1);
    BATT_FAIL = 1'b1;
    cyc(4);
    `CHK("tamper_early", 1'b0, LED_TAMPER)
    cyc(1);
    `CHK("tamper", 1'b1, LED_TAMPER)
    `CHK("latch_set", 1'b1, TAMPER_SET)
    `CHK("periph", 1'b0, PERIPH_CONNECT | PROG_PORT_EN)
    BATT_FAIL = 1'b0;
  endtask
  task t_open;
    boot(1'b1, 1'b0, 1'b0, 1'b1);
    TAMPER_OPEN = 1'b1;
    cyc(6);
    `CHK("tamper", 1'b1, LED_TAMPER)
    TAMPER_OPEN = 1'b0;
    boot(1'b1, 1'b0, 1'b0, 1'b0);
    `CHK("kept", 1'b1, LED_TAMPER)
    `CHK("periph", 1'b0, PERIPH_CONNECT | LED_READY)
    `CHK("copy_len", 8'h00, copy_cyc)
  endtask
  // Main power absent: the sensor trips while the design is held in reset
  task t_unpowered;
    RST = 1'b1;
    new_unit = 1'b1;
    cyc(2);
    new_unit = 1'b0;
    TAMPER_OPEN = 1'b1;
    cyc(2);
    TAMPER_OPEN = 1'b0;
    boot(1'b1, 1'b0, 1'b0, 1'b0);
    `CHK("tamper", 1'b1, LED_TAMPER)
    `CHK("periph", 1'b0, PERIPH_CONNECT | VIDEO_ENABLE)
  endtask
  task final_report;
    if (err_total == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    t_pass_boot();
    t_host_wr();
    t_fail_boot();
    t_timeout();
    t_armed();
    t_mon_fail();
    t_batt();
    t_open();
    t_unpowered();
    final_report();
  end
  // Run needs about five hundred cycles; forty times that means a hang
  initial begin
    #1000000;
    err_total++;
    final_report();
  end
endmodule
`default_nettype wire
